// ---- hdl/smcp_fifo.sv ----
// Purpose: word FIFO between frame capture and configuration update
// Assumes: single clock
// Notes:   extra pointer bit tells full from empty
`timescale 1ns/10ps
`default_nettype none
module smcp_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ff;
    logic [AW:0] rd_ff;
    logic push;
    logic pop;
    // ==========================================================
    // Flags
    assign in_ready = (wr_ff[AW] != rd_ff[AW]) ? (wr_ff[AW-1:0] != rd_ff[AW-1:0]) : 1'b1;
    assign out_valid = (wr_ff != rd_ff);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ff[AW-1:0]];
    // Storage, no reset needed for data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end
    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/smcp_spi_link.sv ----
// Purpose: serial shift register on the link clock
// Assumes: clock idles low, frame bounded by chip select
// Notes:   no edge is relied upon outside a frame
`timescale 1ns/10ps
`default_nettype none
module smcp_spi_link (
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    smcp_link_if.link lnk
);
    import smcp_pkg::*;
    smcp_word_type shift_ff;
    smcp_word_type rx_ff;
    smcp_word_type word;
    logic loaded_ff;
    logic tog_ff;
    // ==========================================================
    // Before the first falling edge the status snapshot is the word
    assign word = loaded_ff ? shift_ff : lnk.status_word;
    assign lnk.rx_word = rx_ff;
    assign lnk.frame_tog = tog_ff;
    // Chip select high forgets the load, ready for next frame
    always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            loaded_ff <= 1'b0;
        end else if (cs_n) begin
            loaded_ff <= 1'b0;
        end else begin
            loaded_ff <= 1'b1;
        end
    end
    // Input shift on falling edge; old bits flow on toward sdo
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_ff <= '0;
        end else if (!cs_n) begin
            shift_ff <= {word[NCH-2:0], sdi};
        end
    end
    // Output on rising edge, released at once by chip select
    // Reset clears too: a select pin that never rises must not leave the enable unknown
    always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (cs_n) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo <= word[NCH-1];
            sdo_oe <= 1'b1;
        end
    end
    // Commit at chip select rise; toggle tells the core
    always_ff @(posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            rx_ff <= '0;
            tog_ff <= 1'b0;
        end else begin
            rx_ff <= shift_ff;
            tog_ff <= ~tog_ff;
        end
    end
    // ==========================================================
    // Checks
    shift_in_a: assert property (@(negedge sclk) disable iff (!rst_n)
        !cs_n |=> shift_ff[0] == $past(sdi)) else $error("input bit not shifted");
    drive_out_a: assert property (@(negedge sclk) disable iff (!rst_n)
        !cs_n |-> sdo_oe && sdo == word[NCH-1]) else $error("sdo not updated");
    hold_commit_a: assert property (@(negedge sclk) disable iff (!rst_n)
        !cs_n && loaded_ff |-> $stable(rx_ff)) else $error("word committed mid frame");
endmodule
`default_nettype wire

// ---- hdl/smcp_top.sv ----
// Purpose: serial control and status port of a 24 channel contact monitor
// Assumes: serial clock is the link clock; pins are asynchronous
// Notes:   long counts are parameters so benches may shorten them
//
// What this block does
// - Serial input bit shifts in on each falling clock edge while selected.
// - Serial output changes on each rising clock edge while selected.
// - Serial output is released whenever chip select is high.
// - Shifted word takes effect only at chip select rising edge.
// - Output feeds next device input; chain shifts as one register.
// - Alert driven low when an enabled contact input changes.
// - Alert driven low when overtemperature is flagged, regardless of inputs.
// - Supply above limit stops sensing current and input monitoring.
// - After supply recovers, wait blanking time before polling again.
// - Sensing current only during active part of each polling period.
// - Normal operation within bounded wake time after leaving power down.
// - Polling active time and period stay near programmed nominal.
// - All alert enable bits are clear after power up.
// - Contact change counts only after persisting for the deglitch window.
`timescale 1ns/10ps
`default_nettype none
module smcp_top #(
    parameter int DEGLITCH_CYC = smcp_pkg::DEGLITCH_CYC,
    parameter int BLANK_CYC = smcp_pkg::BLANK_CYC,
    parameter int WAKE_CYC = smcp_pkg::WAKE_CYC,
    parameter int POLL_PERIOD_CYC = smcp_pkg::POLL_PERIOD_CYC,
    parameter int POLL_ACT_CYC = smcp_pkg::POLL_ACT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic alert_n_o,
    output logic alert_n_oe,
    input wire logic power_down_n,
    input wire logic [smcp_pkg::NCH-1:0] contact_inputs,
    input wire logic vs_over,
    input wire logic over_temp,
    output logic sense_en
);
    import smcp_pkg::*;

    // ==========================================================
    // Declarations
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic tog_seen_ff;
    smcp_state_type state_ff;
    smcp_state_type nxt_state;
    logic [CNT_W-1:0] tmr_ff;
    logic [CNT_W-1:0] poll_ff;
    logic [CNT_W-1:0] dg_cnt_ff [NCH];
    smcp_word_type sw_state_ff;
    smcp_word_type status_ff;
    smcp_word_type pend_ff;
    smcp_word_type alert_en_ff;
    smcp_word_type chg;
    smcp_word_type fifo_out;
    logic alert_ff;
    logic sense_ff;
    logic pd_s;
    logic vs_s;
    logic ot_s;
    logic cs_idle;
    logic frame_done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic pop;
    logic monitor;
    logic in_active;

    smcp_link_if lnk_if ();

    // Counter reached its limit; shared by all timers
    function automatic logic reached(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
        reached = (cnt >= lim - CNT_ONE);
    endfunction

    // ==========================================================
    // Link side
    smcp_spi_link u_link (
        .rst_n(rst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .lnk(lnk_if.link)
    );

    // ==========================================================
    // Synchronisers: pins and the frame toggle cross here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= {cs_n, lnk_if.frame_tog, over_temp, vs_over, power_down_n, contact_inputs};
            sync2_ff <= sync1_ff;
        end
    end

    assign pd_s = sync2_ff[SY_PD];
    assign vs_s = sync2_ff[SY_VS];
    assign ot_s = sync2_ff[SY_OT];
    assign cs_idle = sync2_ff[SY_CS];
    assign frame_done = (sync2_ff[SY_TOG] != tog_seen_ff);

    // Toggle edge detect, reads the second stage only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_seen_ff <= 1'b0;
        end else begin
            tog_seen_ff <= sync2_ff[SY_TOG];
        end
    end

    // ==========================================================
    // Operating state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_DOWN: begin
                if (pd_s) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (reached(tmr_ff, CNT_W'(WAKE_CYC))) begin
                    nxt_state = vs_s ? ST_HALT : ST_RUN;
                end
            end
            ST_HALT: begin
                if (!vs_s) begin
                    nxt_state = ST_BLANK;
                end
            end
            ST_BLANK: begin
                if (vs_s) begin
                    nxt_state = ST_HALT;
                end else if (reached(tmr_ff, CNT_W'(BLANK_CYC))) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (vs_s) begin
                    nxt_state = ST_HALT;
                end
            end
            default: begin
                nxt_state = ST_DOWN;
            end
        endcase
        if (!pd_s) begin
            nxt_state = ST_DOWN;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_DOWN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Wake and blanking timer restarts on every state change
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_ff <= '0;
        end else if (nxt_state != state_ff) begin
            tmr_ff <= '0;
        end else begin
            tmr_ff <= tmr_ff + CNT_ONE;
        end
    end

    // ==========================================================
    // Polling period; sensing only in the active part
    assign monitor = (state_ff == ST_RUN);
    assign in_active = (poll_ff < CNT_W'(POLL_ACT_CYC));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_ff <= '0;
        end else if (!monitor || reached(poll_ff, CNT_W'(POLL_PERIOD_CYC))) begin
            poll_ff <= '0;
        end else begin
            poll_ff <= poll_ff + CNT_ONE;
        end
    end

    // Sense current off outside the window and above supply limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_ff <= 1'b0;
        end else begin
            sense_ff <= monitor && in_active && !vs_s;
        end
    end
    assign sense_en = sense_ff;

    // ==========================================================
    // Deglitch: a new level must hold the whole window while sensed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_state_ff <= '0;
            for (int i = 0; i < NCH; i++) begin
                dg_cnt_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!sense_ff || sync2_ff[i] == sw_state_ff[i]) begin
                    dg_cnt_ff[i] <= '0;
                end else if (reached(dg_cnt_ff[i], CNT_W'(DEGLITCH_CYC))) begin
                    dg_cnt_ff[i] <= '0;
                    sw_state_ff[i] <= sync2_ff[i];
                end else begin
                    dg_cnt_ff[i] <= dg_cnt_ff[i] + CNT_ONE;
                end
            end
        end
    end

    // Confirmed changes this cycle
    always_comb begin
        chg = '0;
        for (int i = 0; i < NCH; i++) begin
            chg[i] = sense_ff && (sync2_ff[i] != sw_state_ff[i]) &&
                     reached(dg_cnt_ff[i], CNT_W'(DEGLITCH_CYC));
        end
    end

    // ==========================================================
    // Status snapshot frozen while selected so the link sees a steady word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else if (cs_idle) begin
            status_ff <= sw_state_ff;
        end
    end
    assign lnk_if.status_word = status_ff;

    // ==========================================================
    // Frames queue up; applied only while running, so the queue can fill
    // A frame that meets a full queue is dropped
    smcp_fifo #(
        .W(NCH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_valid(frame_done),
        .in_ready(fifo_in_ready),
        .in_data(lnk_if.rx_word),
        .out_valid(fifo_out_valid),
        .out_ready(monitor),
        .out_data(fifo_out)
    );
    assign pop = fifo_out_valid && monitor;

    // Alert enables clear at power up, loaded from committed frames
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_en_ff <= ALERT_EN_RST;
        end else if (pop) begin
            alert_en_ff <= fifo_out;
        end
    end

    // ==========================================================
    // Pending changes: a read clears, a new change in that cycle wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= '0;
        end else if (frame_done) begin
            pend_ff <= chg;
        end else begin
            pend_ff <= pend_ff | chg;
        end
    end

    // Open drain alert: pin driven low while enable is high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_ff <= 1'b0;
        end else begin
            alert_ff <= (|(pend_ff & alert_en_ff)) || ot_s;
        end
    end
    assign alert_n_oe = alert_ff;

    // Constant low level, only the enable moves
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_o <= 1'b0;
        end else begin
            alert_n_o <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    sequence blank_exit;
        state_ff == ST_BLANK ##1 state_ff == ST_RUN;
    endsequence

    enabled_alert_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (|(pend_ff & alert_en_ff)) |=> alert_n_oe) else $error("enabled change gave no alert");
    temp_alert_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ot_s |=> alert_n_oe) else $error("overtemperature gave no alert");
    supply_halt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vs_s |-> ##2 !sense_en) else $error("sensing during high supply");
    blank_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        blank_exit |-> $past(tmr_ff) == CNT_W'(BLANK_CYC - 1)) else $error("blanking cut short");
    sense_window_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sense_en |-> $past(poll_ff) < CNT_W'(POLL_ACT_CYC) && $past(monitor)) else $error("sense outside window");
    wake_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_ff == ST_WAKE |-> tmr_ff < CNT_W'(WAKE_MAX_CYC)) else $error("wake too long");
    poll_period_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        poll_ff < CNT_W'(POLL_PERIOD_CYC)) else $error("poll period overrun");
    enable_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$stable(alert_en_ff) |-> $past(pop)) else $error("enables changed without frame");
    deglitch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$stable(sw_state_ff) |-> $past(|chg)) else $error("change taken before window");
    read_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        frame_done |=> pend_ff == $past(chg)) else $error("read did not clear pending");
    release_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cs_idle |-> !sdo_oe) else $error("sdo driven while deselected");
endmodule
`default_nettype wire

// ---- inc/smcp_link_if.sv ----
// Purpose: words between the core domain and the serial clock domain
// Assumes: status_word stable while a frame runs
// Notes:   rx_word changes only with frame_tog
`timescale 1ns/10ps
`default_nettype none
interface smcp_link_if;
    import smcp_pkg::*;
    smcp_word_type status_word;
    smcp_word_type rx_word;
    logic frame_tog;
    modport core (output status_word, input rx_word, input frame_tog);
    modport link (input status_word, output rx_word, output frame_tog);
endinterface
`default_nettype wire

// ---- inc/smcp_pkg.sv ----
// Purpose: shared constants and types of the switch monitor serial port
// Assumes: core clock of 200 MHz
// Notes:   times kept in microseconds, cycle counts derived from them
package smcp_pkg;
    // ==========================================================
    // Widths
    localparam int NCH = 24;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 32;
    // ==========================================================
    // Timing, figures in their own unit
    localparam int CORE_MHZ = 200;
    localparam int DEGLITCH_US = 50;
    localparam int BLANK_US = 1000;
    localparam int WAKE_US = 100;
    localparam int WAKE_MAX_US = 1000;
    localparam int POLL_PERIOD_US = 64000;
    localparam int POLL_ACT_US = 1000;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CORE_MHZ;
    localparam int BLANK_CYC = BLANK_US * CORE_MHZ;
    localparam int WAKE_CYC = WAKE_US * CORE_MHZ;
    localparam int WAKE_MAX_CYC = WAKE_MAX_US * CORE_MHZ;
    localparam int POLL_PERIOD_CYC = POLL_PERIOD_US * CORE_MHZ;
    localparam int POLL_ACT_CYC = POLL_ACT_US * CORE_MHZ;
    // ==========================================================
    // Synchroniser vector layout and reset values
    localparam int SY_PD = 24;
    localparam int SY_VS = 25;
    localparam int SY_OT = 26;
    localparam int SY_TOG = 27;
    localparam int SY_CS = 28;
    localparam int SYNC_W = 29;
    localparam logic [28:0] SYNC_RST = 29'h1000_0000;
    localparam logic [23:0] ALERT_EN_RST = 24'h00_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    // ==========================================================
    // Types
    typedef logic [23:0] smcp_word_type;
    typedef enum logic [4:0] {
        ST_DOWN  = 5'h01,
        ST_WAKE  = 5'h02,
        ST_HALT  = 5'h04,
        ST_BLANK = 5'h08,
        ST_RUN   = 5'h10
    } smcp_state_type;
endpackage

// ---- testbench/smcp_host_model.sv ----
// Purpose: host side of the serial port, one frame at a time
// Assumes: link clock of 48 ns, idle low and stopped between frames
// Notes:   a released data line reads as the inverse of the last bit
`timescale 1ns/10ps
`default_nettype none
module smcp_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic last_q;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        last_q = 1'b0;
    end
    // ==========================================================
    // Frame of 48 clocks, so the device also acts as a chain link
    task automatic xfer(input logic [47:0] tx, output logic [47:0] rx);
        logic bit_v;
        #3 cs_n = 1'b0;
        #86;
        for (int i = 47; i >= 0; i--) begin
            sdi = tx[i];
            #14 sclk = 1'b1;
            #24 bit_v = sdo_oe ? sdo : ~last_q;
            last_q = bit_v;
            rx[i] = bit_v;
            sclk = 1'b0;
            #10;
        end
        #90 cs_n = 1'b1;
        sdi = 1'b0; // Pulldown level once released
        #150;
    endtask
endmodule
`default_nettype wire

// ---- testbench/switch_monitor_serial_port_tb.sv ----
// Purpose: self-checking bench of the contact monitor serial port
// Assumes: shortened counts, host model drives the link
// Notes:   inputs change 1 ns after the core clock edge
`timescale 1ns/10ps
`default_nettype none
module switch_monitor_serial_port_tb;
    import smcp_pkg::*;
    localparam int DG = 8;
    localparam int BL = 20;
    localparam int WK = 10;
    localparam int PP = 64;
    localparam int PA = 16;
    localparam logic [23:0] PAT = 24'ha5_0f3c;
    logic core_clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe;
    logic alert_n_o, alert_n_oe, power_down_n, vs_over, over_temp, sense_en;
    logic [NCH-1:0] contact_inputs;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    smcp_top #(.DEGLITCH_CYC(DG), .BLANK_CYC(BL), .WAKE_CYC(WK), .POLL_PERIOD_CYC(PP),
        .POLL_ACT_CYC(PA)) u_smcp_top (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .alert_n_o(alert_n_o),
        .alert_n_oe(alert_n_oe), .power_down_n(power_down_n), .contact_inputs(contact_inputs),
        .vs_over(vs_over), .over_temp(over_temp), .sense_en(sense_en));
    smcp_host_model u_smcp_host_model (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe));
    // ==========================================================
    // Shared helpers
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait so a stuck sense output cannot hang the run
    task automatic wait_sense(input logic lvl, input int lim, output int n);
        n = 0;
        while (sense_en !== lvl && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic frame(input logic [47:0] tx, output logic [47:0] rx);
        u_smcp_host_model.xfer(tx, rx);
        tick(1);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_power_up();
        int n;
        chk("alert_oe", 48'h0, alert_n_oe);
        chk("sdo_oe", 48'h0, sdo_oe);
        chk("sense_en", 48'h0, sense_en);
        power_down_n = 1'b1;
        wait_sense(1'b1, 10 * WK + PP, n);
        chk("wake", 48'h1, n < 10 * WK + PP);
        wait_sense(1'b0, PP, n);
        chk("active", PA, n);
        wait_sense(1'b1, PP, n);
        chk("period", PP - PA, n);
        $display("test power_up done");
    endtask
    task automatic t_read();
        logic [47:0] rx;
        contact_inputs = PAT;
        tick(3 * PP);
        contact_inputs[2] = 1'b0; // Glitch shorter than the window
        tick(DG / 2);
        contact_inputs[2] = 1'b1;
        tick(3 * PP);
        frame({24'h5a_c3f0, 24'h00_0000}, rx);
        chk("status", PAT, rx[47:24]);
        chk("chain", 24'h5a_c3f0, rx[23:0]);
        chk("sdo_oe", 48'h0, sdo_oe);
        chk("alert_oe", 48'h0, alert_n_oe);
        $display("test read done");
    endtask
    task automatic t_alert();
        logic [47:0] rx;
        frame({24'h00_0000, 24'h00_0001}, rx);
        tick(4);
        chk("alert_oe", 48'h0, alert_n_oe);
        contact_inputs[0] = ~contact_inputs[0];
        tick(3 * PP);
        chk("alert_oe", 48'h1, alert_n_oe);
        chk("alert_lvl", 48'h0, alert_n_o);
        frame({24'h00_0000, 24'h00_0001}, rx);
        chk("status", PAT ^ 24'h00_0001, rx[47:24]);
        tick(4);
        chk("alert_oe", 48'h0, alert_n_oe);
        contact_inputs[1] = ~contact_inputs[1];
        tick(3 * PP);
        chk("alert_oe", 48'h0, alert_n_oe);
        $display("test alert done");
    endtask
    task automatic t_temp();
        logic [47:0] rx;
        over_temp = 1'b1;
        tick(4);
        chk("alert_oe", 48'h1, alert_n_oe);
        frame({24'h00_0000, 24'h00_0001}, rx);
        chk("alert_oe", 48'h1, alert_n_oe);
        over_temp = 1'b0;
        frame({24'h00_0000, 24'h00_0001}, rx);
        tick(4);
        chk("alert_oe", 48'h0, alert_n_oe);
        $display("test temp done");
    endtask
    task automatic t_supply();
        int n;
        wait_sense(1'b1, 2 * PP, n);
        vs_over = 1'b1;
        tick(6);
        chk("sense_en", 48'h0, sense_en);
        contact_inputs[0] = ~contact_inputs[0];
        tick(3 * PP);
        chk("sense_en", 48'h0, sense_en);
        chk("alert_oe", 48'h0, alert_n_oe);
        vs_over = 1'b0;
        wait_sense(1'b1, 3 * PP, n);
        chk("blank", 48'h1, n > BL && n < 3 * PP);
        power_down_n = 1'b0;
        tick(6);
        chk("sense_en", 48'h0, sense_en);
        power_down_n = 1'b1;
        wait_sense(1'b1, 10 * WK, n);
        chk("rewake", 48'h1, n >= WK && n < 10 * WK);
        $display("test supply done");
    endtask
    // ==========================================================
    // Clock, reset, sequence and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        power_down_n = 1'b0;
        contact_inputs = 24'h00_0000;
        vs_over = 1'b0;
        over_temp = 1'b0;
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        tick(2);
        t_power_up();
        t_read();
        t_alert();
        t_temp();
        t_supply();
        results();
    end
endmodule
`default_nettype wire
